// ===== pkg/anpa_consts.svh
`ifndef ANPA_CONSTS_SVH
`define ANPA_CONSTS_SVH
`define ANPA_OFF_CONTROL   32'h0000_0000
`define ANPA_OFF_PARTNER   32'h0000_0004
`define ANPA_OFF_STATUS    32'h0000_0008
`define ANPA_SEL_LSB       0
`define ANPA_SEL_MSB       4
`define ANPA_TECH_LSB      5
`define ANPA_TECH_MSB      12
`define ANPA_RFAULT_BIT    13
`define ANPA_ACK_BIT       14
`define ANPA_NP_BIT        15
`define ANPA_CTRL_FIXED    16'h007F
`define ANPA_CTRL_RESET    16'h0000
`define ANPA_PARTNER_RESET 16'h0000
`define ANPA_ST_VALID_BIT  0
`define ANPA_ST_RESET_BIT  1
`define ANPA_ST_RESTART_BIT 2
`define ANPA_CTRL_RST_BIT  15
`define ANPA_CTRL_RESTART_BIT 9
`define ANPA_CTRL_ENABLE_BIT  12
`endif

// ===== pkg/anpa_pkg.sv
`default_nettype none
package anpa_pkg;
  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic        valid;
  } anpa_req_t;
endpackage : anpa_pkg
`default_nettype wire

// ===== src/anpa_capture.sv
`timescale 1ns/100ps
`default_nettype none
`include "anpa_consts.svh"
module anpa_capture (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Received code word
  input  wire logic        clr,
  input  wire logic        word_valid,
  input  wire logic [15:0] word_in,
  // Captured word
  output logic [15:0]      word_reg,
  output logic             have_reg
);
  // Whole word stored as sent; no field is altered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      word_reg <= `ANPA_PARTNER_RESET;
    end else if (word_valid) begin
      word_reg <= word_in;
    end else if (clr) begin
      word_reg <= `ANPA_PARTNER_RESET;
    end
  end
  // New word wins over clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      have_reg <= 1'b0;
    end else if (word_valid) begin
      have_reg <= 1'b1;
    end else if (clr) begin
      have_reg <= 1'b0;
    end
  end
endmodule : anpa_capture
`default_nettype wire

// ===== src/anpa_regs.sv
// The address map and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "anpa_consts.svh"
module anpa_regs (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Negotiation engine
  input  wire logic        rx_word_valid,
  input  wire logic [15:0] rx_word,
  input  wire logic        an_reset_done,
  output logic             an_reset_reg,
  output logic             an_restart_reg,
  output logic             an_enable_reg
);
  anpa_pkg::anpa_req_t req_reg;
  logic [15:0]         ctrl_reg;
  logic [15:0]         partner_word;
  logic                partner_have;
  logic                start;
  logic                wr_ctrl;

  // Only whole aligned words are mapped, so byte lanes are dropped
  function automatic logic [31:0] word_addr(input logic [31:0] byte_addr);
    word_addr = {byte_addr[31:2], 2'b00};
  endfunction : word_addr

  // Fixed low field cleared wherever a control value is formed
  function automatic logic [15:0] ctrl_mask(input logic [15:0] value);
    ctrl_mask = value & ~`ANPA_CTRL_FIXED;
  endfunction : ctrl_mask

  assign start   = hsel && hready && htrans[1];
  assign wr_ctrl = req_reg.valid && req_reg.write && (req_reg.addr == `ANPA_OFF_CONTROL);

  anpa_capture u_cap (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .clr        (an_reset_reg),
    .word_valid (rx_word_valid),
    .word_in    (rx_word),
    .word_reg   (partner_word),
    .have_reg   (partner_have)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_reg <= '0;
    end else begin
      req_reg.addr  <= word_addr(haddr);
      req_reg.write <= hwrite;
      req_reg.valid <= start;
    end
  end

  // Stored control; low field forced to zero, self-clearing reset/restart
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= `ANPA_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= ctrl_mask(hwdata[15:0]);
    end else begin
      if (an_reset_done) begin
        ctrl_reg[`ANPA_CTRL_RST_BIT] <= 1'b0;
      end
      if (an_restart_reg) begin
        ctrl_reg[`ANPA_CTRL_RESTART_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      an_reset_reg   <= 1'b0;
      an_restart_reg <= 1'b0;
      an_enable_reg  <= 1'b0;
    end else begin
      an_reset_reg   <= ctrl_reg[`ANPA_CTRL_RST_BIT];
      an_restart_reg <= ctrl_reg[`ANPA_CTRL_RESTART_BIT] && !an_restart_reg;
      an_enable_reg  <= ctrl_reg[`ANPA_CTRL_ENABLE_BIT];
    end
  end

  // Read data registered at address phase; one-cycle wait-free answer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (start && !hwrite) begin
      unique case (word_addr(haddr))
        `ANPA_OFF_CONTROL: hrdata <= {16'h0000, ctrl_mask(ctrl_reg)};
        `ANPA_OFF_PARTNER: hrdata <= {16'h0000, partner_word};
        `ANPA_OFF_STATUS:  hrdata <= {29'h0000000, an_restart_reg, an_reset_reg, partner_have};
        default:           hrdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Address phases of reads, one per mapped register and one for the rest
  sequence ctrl_read_s;
    start && !hwrite && (word_addr(haddr) == `ANPA_OFF_CONTROL);
  endsequence

  sequence partner_read_s;
    start && !hwrite && (word_addr(haddr) == `ANPA_OFF_PARTNER);
  endsequence

  sequence status_read_s;
    start && !hwrite && (word_addr(haddr) == `ANPA_OFF_STATUS);
  endsequence

  sequence other_read_s;
    start && !hwrite && (word_addr(haddr) != `ANPA_OFF_CONTROL) &&
      (word_addr(haddr) != `ANPA_OFF_PARTNER) && (word_addr(haddr) != `ANPA_OFF_STATUS);
  endsequence

  // Data phase of a software write aimed at the read-only word
  sequence partner_write_s;
    req_reg.valid && req_reg.write && (req_reg.addr == `ANPA_OFF_PARTNER);
  endsequence

  // Restart bit set, then one pulse to the engine, then silence
  sequence restart_req_s;
    $rose(ctrl_reg[`ANPA_CTRL_RESTART_BIT]);
  endsequence

  sequence restart_pulse_s;
    an_restart_reg ##1 !an_restart_reg;
  endsequence

  sequence reset_req_s;
    $rose(ctrl_reg[`ANPA_CTRL_RST_BIT]);
  endsequence

  // Capture of the received code word
  partner_ro_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !rx_word_valid
    |=> $stable(partner_word) || $past(an_reset_reg))
    else $error("partner word changed without a received word");

  partner_cap_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_word_valid
    |=> partner_word == $past(rx_word))
    else $error("partner word not captured");

  sel_bits_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_word_valid
    |=> partner_word[`ANPA_SEL_MSB:`ANPA_SEL_LSB] == $past(rx_word[4:0]))
    else $error("selector field wrong");

  tech_bits_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_word_valid
    |=> partner_word[12:5] == $past(rx_word[12:5]))
    else $error("technology bits wrong");

  fault_bit_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_word_valid
    |=> partner_word[`ANPA_RFAULT_BIT] == $past(rx_word[13]))
    else $error("remote fault bit wrong");

  ack_bit_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_word_valid
    |=> partner_word[`ANPA_ACK_BIT] == $past(rx_word[14]))
    else $error("ack bit wrong");

  np_bit_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_word_valid
    |=> partner_word[`ANPA_NP_BIT] == $past(rx_word[15]))
    else $error("next page bit wrong");

  have_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_word_valid
    |=> partner_have)
    else $error("received word not flagged");

  partner_wr_a: assert property (@(posedge hclk) disable iff (!hresetn)
    partner_write_s ##0 (!rx_word_valid && !an_reset_reg)
    |=> $stable(partner_word))
    else $error("software write altered partner word");

  reset_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    an_reset_reg && !rx_word_valid
    |=> partner_word == `ANPA_PARTNER_RESET && !partner_have)
    else $error("partner word kept through negotiation reset");

  // Register reads; data stands from the data phase until the next read
  ctrl_rd_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl_read_s
    |=> hrdata[31:16] == 16'h0000 && hrdata[15:7] == $past(ctrl_reg[15:7]) && hrdata[6:0] == 7'h00)
    else $error("control read data wrong");

  partner_rd_a: assert property (@(posedge hclk) disable iff (!hresetn)
    partner_read_s
    |=> hrdata == {16'h0000, $past(partner_word)})
    else $error("partner read data wrong");

  status_rd_a: assert property (@(posedge hclk) disable iff (!hresetn)
    status_read_s
    |=> hrdata == {29'h0000000, $past(an_restart_reg), $past(an_reset_reg), $past(partner_have)})
    else $error("status read data wrong");

  other_rd_a: assert property (@(posedge hclk) disable iff (!hresetn)
    other_read_s
    |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  rdata_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !(start && !hwrite)
    |=> $stable(hrdata))
    else $error("read data changed without a read");

  // Bus handshake; the slave never stretches or rejects a transfer
  ready_high_a: assert property (@(posedge hclk) disable iff (!hresetn)
    start
    |=> hreadyout)
    else $error("wait state inserted");

  resp_okay_a: assert property (@(posedge hclk) disable iff (!hresetn)
    start
    |=> !hresp)
    else $error("error response given");

  // Control register and the engine outputs that follow it
  ctrl_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl_reg[6:0] == 7'h00)
    else $error("control low field not zero");

  ctrl_wr_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ctrl
    |=> ctrl_reg[15:13] == $past(hwdata[15:13]) && ctrl_reg[11:10] == $past(hwdata[11:10]))
    else $error("control write lost");

  ctrl_wr_mid_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_ctrl
    |=> ctrl_reg[12] == $past(hwdata[12]) && ctrl_reg[9:7] == $past(hwdata[9:7]))
    else $error("control middle bits lost");

  ctrl_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !wr_ctrl
    |=> ctrl_reg[14:10] == $past(ctrl_reg[14:10]) && ctrl_reg[8:7] == $past(ctrl_reg[8:7]))
    else $error("control bits changed without a write");

  enable_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1
    |=> an_enable_reg == $past(ctrl_reg[`ANPA_CTRL_ENABLE_BIT]))
    else $error("enable output lags control");

  reset_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
    reset_req_s
    |=> an_reset_reg)
    else $error("reset request not passed on");

  reset_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1
    |=> an_reset_reg == $past(ctrl_reg[`ANPA_CTRL_RST_BIT]))
    else $error("reset output lags control");

  reset_done_a: assert property (@(posedge hclk) disable iff (!hresetn)
    an_reset_done && !wr_ctrl
    |=> !ctrl_reg[`ANPA_CTRL_RST_BIT])
    else $error("reset bit not cleared when done");

  restart_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
    restart_req_s
    |=> restart_pulse_s)
    else $error("restart request gave no single pulse");

  restart_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
    an_restart_reg
    |=> !an_restart_reg)
    else $error("restart held");

  restart_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    an_restart_reg && !wr_ctrl
    |=> !ctrl_reg[`ANPA_CTRL_RESTART_BIT])
    else $error("restart bit not self-cleared");
endmodule : anpa_regs
`default_nettype wire

// ===== dv/anpa_partner.sv
`timescale 1ns/100ps
`default_nettype none
module anpa_partner (
  // Clock
  input  wire logic        hclk,
  // Bench request
  input  wire logic        send,
  input  wire logic [15:0] word,
  // Engine side
  input  wire logic        an_reset_reg,
  output logic             rx_word_valid,
  output logic [15:0]      rx_word,
  output logic             an_reset_done
);
  initial begin
    rx_word_valid = 1'b0;
    rx_word = 16'h0000;
    an_reset_done = 1'b0;
  end
  // Word stands one cycle, then inverts so a stale capture shows
  always @(posedge hclk) begin
    rx_word_valid <= send;
    rx_word <= send ? word : ~rx_word;
    an_reset_done <= an_reset_reg & ~an_reset_done;
  end
endmodule : anpa_partner
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "anpa_consts.svh"
module tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0, hready, hresp, send = 1'b0;
  logic [15:0] word = 16'h0000, rx_word;
  logic        rx_word_valid, an_reset_done, an_reset_reg, an_restart_reg, an_enable_reg;
  logic [15:0] pats [10] = '{16'h0001, 16'h0021, 16'h0041, 16'h0081, 16'h0101,
                             16'h1FE1, 16'h2001, 16'h4001, 16'h8001, 16'h001F};
  int          miscompares = 0, compares = 0;
  always #50 hclk = ~hclk;
  anpa_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .rx_word_valid(rx_word_valid), .rx_word(rx_word), .an_reset_done(an_reset_done),
    .an_reset_reg(an_reset_reg), .an_restart_reg(an_restart_reg), .an_enable_reg(an_enable_reg));
  anpa_partner partner (.hclk(hclk), .send(send), .word(word), .an_reset_reg(an_reset_reg),
    .rx_word_valid(rx_word_valid), .rx_word(rx_word), .an_reset_done(an_reset_done));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : xfer
  task automatic t_reset();
    xfer(1'b0, `ANPA_OFF_CONTROL, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b0, `ANPA_OFF_PARTNER, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b0, 32'h0000_0010, 32'h0);
    chk(rd, 32'h0);
  endtask : t_reset
  // Selector 00001 from a conforming partner, then each field alone
  task automatic t_partner();
    foreach (pats[i]) begin
      word <= pats[i];
      send <= 1'b1;
      @(posedge hclk);
      send <= 1'b0;
      repeat (2) @(posedge hclk);
      xfer(1'b0, `ANPA_OFF_PARTNER, 32'h0);
      chk(rd, {16'h0, pats[i]});
    end
    xfer(1'b1, `ANPA_OFF_PARTNER, 32'hFFFF_0000);
    xfer(1'b0, `ANPA_OFF_PARTNER, 32'h0);
    chk(rd, 32'h0000_001F);
    xfer(1'b0, `ANPA_OFF_STATUS, 32'h0);
    chk(rd, 32'h0000_0001);
  endtask : t_partner
  task automatic t_ctrl();
    xfer(1'b1, `ANPA_OFF_CONTROL, 32'h0000_11FF);
    xfer(1'b0, `ANPA_OFF_CONTROL, 32'h0);
    chk(rd, 32'h0000_1180);
    chk({31'h0, an_enable_reg}, 32'h1);
    xfer(1'b1, `ANPA_OFF_CONTROL, 32'h0000_1200);
    repeat (2) @(posedge hclk);
    chk({31'h0, an_restart_reg}, 32'h1);
    @(posedge hclk);
    chk({31'h0, an_restart_reg}, 32'h0);
    xfer(1'b0, `ANPA_OFF_CONTROL, 32'h0);
    chk(rd, 32'h0000_1000);
    xfer(1'b1, `ANPA_OFF_CONTROL, 32'h0000_8000);
    repeat (2) @(posedge hclk);
    chk({31'h0, an_reset_reg}, 32'h1);
    repeat (4) @(posedge hclk);
    chk({31'h0, an_enable_reg}, 32'h0);
    xfer(1'b0, `ANPA_OFF_CONTROL, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b0, `ANPA_OFF_PARTNER, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b0, `ANPA_OFF_STATUS, 32'h0);
    chk(rd, 32'h0);
  endtask : t_ctrl
  task automatic give_verdict();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_partner();
    t_ctrl();
    give_verdict();
  end
  // Whole run needs well under 300 cycles
  initial begin
    repeat (3000) @(posedge hclk);
    miscompares++;
    give_verdict();
  end
endmodule : tb
`default_nettype wire
